/* shared/tpcu_pkg.sv */
package tpcu_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned TPCU_AW        = 8;
    localparam logic [7:0]  TPCU_ADDR_CTRL = 8'h00;
    localparam logic [7:0]  TPCU_ADDR_TOP  = 8'h04;
    localparam logic [7:0]  TPCU_ADDR_CMP  = 8'h08;
    localparam logic [7:0]  TPCU_ADDR_COUNT = 8'h0c;
    localparam logic [7:0]  TPCU_ADDR_CAP  = 8'h10;
    localparam logic [7:0]  TPCU_ADDR_CMD  = 8'h14;
    localparam logic [7:0]  TPCU_ADDR_STAT = 8'h18;

    // ************************************************************
    // Field layouts and codes
    // ************************************************************
    typedef struct packed {
        logic       irq_en;
        logic [2:0] div;
        logic [2:0] clksel;
        logic [1:0] ocmode;
        logic [1:0] mode;
    } tpcu_cfg_t;

    localparam int unsigned TPCU_CFG_W = 11;
    localparam tpcu_cfg_t   TPCU_CFG_RST = '{irq_en: 1'b0, div: 3'h0, clksel: 3'h0,
                                             ocmode: 2'h0, mode: 2'h0};

    localparam logic [1:0] TPCU_MODE_WDOG  = 2'h0;
    localparam logic [1:0] TPCU_MODE_CLEAR = 2'h1;
    localparam logic [1:0] TPCU_MODE_FAST  = 2'h2;
    localparam logic [1:0] TPCU_MODE_PHASE = 2'h3;

    localparam logic [1:0] TPCU_OC_ZERO    = 2'h0;
    localparam logic [1:0] TPCU_OC_TOGGLE  = 2'h1;
    localparam logic [1:0] TPCU_OC_CLEAR   = 2'h2;
    localparam logic [1:0] TPCU_OC_SET     = 2'h3;

    localparam int unsigned TPCU_CLK_OSC_BIT  = 1;
    localparam int unsigned TPCU_CLK_FALL_BIT = 2;

    localparam logic [2:0] TPCU_DIV_STOP = 3'h0;
    localparam logic [2:0] TPCU_DIV_1    = 3'h1;
    localparam logic [2:0] TPCU_DIV_8    = 3'h2;
    localparam logic [2:0] TPCU_DIV_64   = 3'h3;
    localparam logic [2:0] TPCU_DIV_256  = 3'h4;
    localparam logic [2:0] TPCU_DIV_1024 = 3'h5;

    localparam logic [9:0] TPCU_LAST_1    = 10'h000;
    localparam logic [9:0] TPCU_LAST_8    = 10'h007;
    localparam logic [9:0] TPCU_LAST_64   = 10'h03f;
    localparam logic [9:0] TPCU_LAST_256  = 10'h0ff;
    localparam logic [9:0] TPCU_LAST_1024 = 10'h3ff;
    localparam logic [9:0] TPCU_PRE_ZERO  = 10'h000;
    localparam logic [9:0] TPCU_PRE_ONE   = 10'h001;

    localparam int unsigned TPCU_CMD_STOP    = 0;
    localparam int unsigned TPCU_CMD_RESET   = 1;
    localparam int unsigned TPCU_CMD_START   = 2;
    localparam int unsigned TPCU_CMD_CAPTURE = 3;

    localparam int unsigned TPCU_ST_TOP = 0;
    localparam int unsigned TPCU_ST_CMP = 1;
    localparam int unsigned TPCU_ST_RUN = 2;

    localparam logic [15:0] TPCU_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] TPCU_COUNT_ONE  = 16'h0001;
    localparam logic [15:0] TPCU_TOP_RST    = 16'hffff;
    localparam logic [15:0] TPCU_CMP_RST    = 16'h0000;
    localparam logic [31:0] TPCU_RD_ZERO    = 32'h0000_0000;

    typedef enum logic [1:0] {
        TPCU_HALT = 2'b01,
        TPCU_RUN  = 2'b10
    } tpcu_run_t;

endpackage

/* verilog/tpcu_prescaler.sv */
`timescale 1ns/1ps
module tpcu_prescaler
    import tpcu_pkg::*;
(
    input  wire logic       sys_clk,  // System clock
    input  wire logic       rst,      // Synchronous reset, active high
    input  wire logic       clear,    // Restart the divider
    input  wire logic       run,      // Counting allowed
    input  wire logic       osc_clk,  // Oscillator level, sampled
    input  wire logic [2:0] clksel,   // Source clock select
    input  wire logic [2:0] div,      // Divider select
    output logic            tick      // One-cycle count enable
);

    logic [9:0] pre_count;
    logic       osc_q;
    logic       src_edge;
    logic       div_on;

    function automatic logic [9:0] div_last(input logic [2:0] code);
        case (code)
            TPCU_DIV_8:    div_last = TPCU_LAST_8;
            TPCU_DIV_64:   div_last = TPCU_LAST_64;
            TPCU_DIV_256:  div_last = TPCU_LAST_256;
            TPCU_DIV_1024: div_last = TPCU_LAST_1024;
            default:       div_last = TPCU_LAST_1;
        endcase
    endfunction

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= osc_clk;
        end
    end

    // Both edges of the system clock give one tick per cycle: a single
    // clock domain cannot count half periods.
    always_comb begin
        if (clksel[TPCU_CLK_OSC_BIT]) begin
            src_edge = clksel[TPCU_CLK_FALL_BIT] ? (osc_q & ~osc_clk)
                                                 : (~osc_q & osc_clk);
        end else begin
            src_edge = 1'b1;
        end
    end

    assign div_on = (div >= TPCU_DIV_1) && (div <= TPCU_DIV_1024);

    always_ff @(posedge sys_clk) begin
        if (rst || clear || !run || !div_on) begin
            pre_count <= TPCU_PRE_ZERO;
            tick      <= 1'b0;
        end else if (src_edge) begin
            if (pre_count == div_last(div)) begin
                pre_count <= TPCU_PRE_ZERO;
                tick      <= 1'b1;
            end else begin
                pre_count <= pre_count + TPCU_PRE_ONE;
                tick      <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_static_no_tick: assert property ((div == TPCU_DIV_STOP) |=> !tick)
        else $error("tick while divider is static");

    chk_osc_edge_only: assert property (
        (clksel[TPCU_CLK_OSC_BIT] && !src_edge) |=> !tick)
        else $error("tick without an oscillator edge");

endmodule // tpcu_prescaler

/* verilog/tpcu_timer.sv */
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - Two-bit mode picks watchdog, clear-on-compare, fast PWM or phase-correct PWM.
// - Output-waveform code 0 keeps the timer output low in every mode.
// - Code 1 toggles on top match, or on compare match in PWM modes.
// - Code 2 clears on top match; fast PWM also sets on compare match.
// - Code 2 phase-correct clears on compare counting up, sets counting down.
// - Code 3 sets on top match; fast PWM also clears on compare match.
// - Code 3 phase-correct sets on compare counting up, clears counting down.
// - Source clock code 2/6 picks oscillator rising or falling; codes 0 and 4 both tick on every bus cycle.
// - Divider code 0 stops counting; 1 to 5 divide by 1,8,64,256,1024.
// - Interrupt output asserts only while the interrupt enable bit is set.
// - A 16-bit top limit, up to all ones, sets the counting period.
// - A 16-bit compare value, up to all ones, drives PWM transitions.
// - Software can read the running 16-bit count at any time.
// - A readable 16-bit capture register holds a snapshot of the count.
// - Separate stop, reset and start requests; reset returns count to zero.
module tpcu_timer
    import tpcu_pkg::*;
(
    input  wire logic               sys_clk,    // System clock, 100 MHz
    input  wire logic               rst,        // Synchronous reset, active high
    input  wire logic               psel,       // APB select
    input  wire logic               penable,    // APB enable
    input  wire logic               pwrite,     // APB write direction
    input  wire logic [TPCU_AW-1:0] paddr,      // APB byte address
    input  wire logic [31:0]        pwdata,     // APB write data
    output logic      [31:0]        prdata,     // APB read data
    output logic                    pready,     // APB ready
    output logic                    pslverr,    // APB error, unmapped address or write to a read-only register
    input  wire logic               osc_clk,    // On-chip oscillator level
    output logic                    timer_out,  // Waveform output
    output logic                    timer_irq   // Interrupt request, active high
);

    // ************************************************************
    // Register state
    // ************************************************************
    tpcu_cfg_t   cfg;
    logic [15:0] top_value;
    logic [15:0] compare_value;
    logic [15:0] count_value;
    logic [15:0] capture_value;
    logic [1:0]  status;
    tpcu_run_t   run_state;
    logic        count_up;
    logic        tick;

    logic        setup_ph;
    logic        wr_en;
    logic        cmd_wr;
    logic        cmd_stop;
    logic        cmd_reset;
    logic        cmd_start;
    logic        cmd_capture;
    logic        top_hit;
    logic        cmp_hit;
    logic        zero_hit;
    logic        top_evt;
    logic        cmp_evt;
    logic        next_out;
    logic [31:0] next_rdata;
    logic        next_err;

    function automatic logic is_pwm(input logic [1:0] mode);
        is_pwm = (mode == TPCU_MODE_FAST) || (mode == TPCU_MODE_PHASE);
    endfunction

    function automatic logic addr_ok(input logic [TPCU_AW-1:0] addr, input logic wr);
        if (addr == TPCU_ADDR_CTRL || addr == TPCU_ADDR_TOP || addr == TPCU_ADDR_CMP) begin
            addr_ok = 1'b1;
        end else if (addr == TPCU_ADDR_CMD || addr == TPCU_ADDR_STAT) begin
            addr_ok = 1'b1;
        end else if (addr == TPCU_ADDR_COUNT || addr == TPCU_ADDR_CAP) begin
            addr_ok = !wr;
        end else begin
            addr_ok = 1'b0;
        end
    endfunction

    // ************************************************************
    // APB slave
    // ************************************************************
    // Read data and error are latched in the setup cycle, so the access
    // phase always completes at once and prdata comes from a flop.
    assign pready      = 1'b1;
    assign setup_ph    = psel && !penable;
    assign wr_en       = psel && penable && pwrite;
    assign cmd_wr      = wr_en && (paddr == TPCU_ADDR_CMD);
    assign cmd_stop    = cmd_wr && pwdata[TPCU_CMD_STOP];
    assign cmd_reset   = cmd_wr && pwdata[TPCU_CMD_RESET];
    assign cmd_start   = cmd_wr && pwdata[TPCU_CMD_START];
    assign cmd_capture = cmd_wr && pwdata[TPCU_CMD_CAPTURE];

    always_comb begin
        next_rdata = TPCU_RD_ZERO;
        if (paddr == TPCU_ADDR_CTRL) begin
            next_rdata[TPCU_CFG_W-1:0] = cfg;
        end else if (paddr == TPCU_ADDR_TOP) begin
            next_rdata[15:0] = top_value;
        end else if (paddr == TPCU_ADDR_CMP) begin
            next_rdata[15:0] = compare_value;
        end else if (paddr == TPCU_ADDR_COUNT) begin
            next_rdata[15:0] = count_value;
        end else if (paddr == TPCU_ADDR_CAP) begin
            next_rdata[15:0] = capture_value;
        end else if (paddr == TPCU_ADDR_STAT) begin
            next_rdata[TPCU_ST_TOP] = status[TPCU_ST_TOP];
            next_rdata[TPCU_ST_CMP] = status[TPCU_ST_CMP];
            next_rdata[TPCU_ST_RUN] = (run_state == TPCU_RUN);
        end
        next_err = !addr_ok(paddr, pwrite);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata  <= TPCU_RD_ZERO;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? TPCU_RD_ZERO : next_rdata;
            pslverr <= next_err;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg           <= TPCU_CFG_RST;
            top_value     <= TPCU_TOP_RST;
            compare_value <= TPCU_CMP_RST;
        end else if (wr_en) begin
            if (paddr == TPCU_ADDR_CTRL) begin
                cfg <= tpcu_cfg_t'(pwdata[TPCU_CFG_W-1:0]);
            end else if (paddr == TPCU_ADDR_TOP) begin
                top_value <= pwdata[15:0];
            end else if (paddr == TPCU_ADDR_CMP) begin
                compare_value <= pwdata[15:0];
            end
        end
    end

    // ************************************************************
    // Run control and clock source
    // ************************************************************
    // Stop beats start when both arrive in one write.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_state <= TPCU_HALT;
        end else begin
            case (run_state)
                TPCU_HALT: if (cmd_start && !cmd_stop) begin
                    run_state <= TPCU_RUN;
                end
                TPCU_RUN: if (cmd_stop) begin
                    run_state <= TPCU_HALT;
                end
                default: run_state <= TPCU_HALT;
            endcase
        end
    end

    tpcu_prescaler u_prescaler (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clear   (cmd_reset),
        .run     (run_state == TPCU_RUN),
        .osc_clk (osc_clk),
        .clksel  (cfg.clksel),
        .div     (cfg.div),
        .tick    (tick)
    );

    // ************************************************************
    // Counter
    // ************************************************************
    assign top_hit  = (count_value == top_value);
    assign cmp_hit  = (count_value == compare_value);
    assign zero_hit = (count_value == TPCU_COUNT_ZERO);
    assign top_evt  = tick && top_hit;
    assign cmp_evt  = tick && cmp_hit;

    always_ff @(posedge sys_clk) begin
        if (rst || cmd_reset) begin
            count_value <= TPCU_COUNT_ZERO;
            count_up    <= 1'b1;
        end else if (tick) begin
            if (cfg.mode == TPCU_MODE_PHASE) begin
                if (count_up && top_hit) begin
                    count_up    <= 1'b0;
                    count_value <= zero_hit ? count_value : count_value - TPCU_COUNT_ONE;
                end else if (!count_up && zero_hit) begin
                    count_up    <= 1'b1;
                    count_value <= top_hit ? count_value : count_value + TPCU_COUNT_ONE;
                end else begin
                    count_value <= count_up ? count_value + TPCU_COUNT_ONE
                                            : count_value - TPCU_COUNT_ONE;
                end
            end else begin
                count_up    <= 1'b1;
                count_value <= top_hit ? TPCU_COUNT_ZERO : count_value + TPCU_COUNT_ONE;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            capture_value <= TPCU_COUNT_ZERO;
        end else if (cmd_capture) begin
            capture_value <= count_value;
        end
    end

    // ************************************************************
    // Waveform output
    // ************************************************************
    // In fast PWM codes 2 and 3 a compare match on the same tick as a top match wins,
    // so a compare value equal to top gives a steady level.
    always_comb begin
        next_out = timer_out;
        case (cfg.ocmode)
            TPCU_OC_ZERO: next_out = 1'b0;
            TPCU_OC_TOGGLE: begin
                if (is_pwm(cfg.mode) ? cmp_evt : top_evt) begin
                    next_out = !timer_out;
                end
            end
            TPCU_OC_CLEAR: begin
                if (cfg.mode == TPCU_MODE_PHASE) begin
                    if (cmp_evt) begin
                        next_out = !count_up;
                    end
                end else if (cfg.mode == TPCU_MODE_FAST && cmp_evt) begin
                    next_out = 1'b1;
                end else if (top_evt) begin
                    next_out = 1'b0;
                end
            end
            default: begin
                if (cfg.mode == TPCU_MODE_PHASE) begin
                    if (cmp_evt) begin
                        next_out = count_up;
                    end
                end else if (cfg.mode == TPCU_MODE_FAST && cmp_evt) begin
                    next_out = 1'b0;
                end else if (top_evt) begin
                    next_out = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst || cmd_reset) begin
            timer_out <= 1'b0;
        end else begin
            timer_out <= next_out;
        end
    end

    // ************************************************************
    // Event flags and interrupt
    // ************************************************************
    // A match in the cycle of its write-one-to-clear keeps the flag set.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status <= 2'h0;
        end else begin
            status[TPCU_ST_TOP] <= top_evt ||
                (status[TPCU_ST_TOP] && !(wr_en && paddr == TPCU_ADDR_STAT
                                          && pwdata[TPCU_ST_TOP]));
            status[TPCU_ST_CMP] <= cmp_evt ||
                (status[TPCU_ST_CMP] && !(wr_en && paddr == TPCU_ADDR_STAT
                                          && pwdata[TPCU_ST_CMP]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= cfg.irq_en && (|status);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence stop_req;
        cmd_stop;
    endsequence

    sequence halted_quiet;
        (run_state == TPCU_HALT) ##1 (!tick) [*3];
    endsequence

    chk_stop_halts_ticks: assert property (stop_req |=> halted_quiet)
        else $error("ticks continued after stop");

    chk_reset_clears_count: assert property (
        cmd_reset |=> count_value == TPCU_COUNT_ZERO)
        else $error("count not zero after reset request");

    chk_oc_zero_low: assert property ((cfg.ocmode == TPCU_OC_ZERO) |=> !timer_out)
        else $error("output high with waveform code zero");

    chk_irq_enable_gate: assert property (!cfg.irq_en |=> !timer_irq)
        else $error("interrupt while disabled");

    chk_clear_wrap_zero: assert property (
        (cfg.mode == TPCU_MODE_CLEAR && top_evt && !cmd_reset)
        |=> (count_value == TPCU_COUNT_ZERO) && status[TPCU_ST_TOP])
        else $error("clear-on-compare did not wrap and flag");

    chk_phase_turn_down: assert property (
        (cfg.mode == TPCU_MODE_PHASE && tick && count_up && top_hit && !zero_hit
         && !cmd_reset)
        |=> !count_up && (count_value == $past(count_value) - TPCU_COUNT_ONE))
        else $error("phase-correct counter did not turn at top");

    chk_pwm_toggle_cmp: assert property (
        (is_pwm(cfg.mode) && cfg.ocmode == TPCU_OC_TOGGLE && cmp_evt && !cmd_reset)
        |=> timer_out != $past(timer_out))
        else $error("no toggle on compare match");

    chk_fast_clear_set: assert property (
        (cfg.mode == TPCU_MODE_FAST && cfg.ocmode == TPCU_OC_CLEAR && cmp_evt
         && !cmd_reset) |=> timer_out)
        else $error("fast PWM did not set on compare");

    chk_fast_set_top: assert property (
        (cfg.mode == TPCU_MODE_FAST && cfg.ocmode == TPCU_OC_SET && top_evt && !cmp_hit
         && !cmd_reset) |=> timer_out)
        else $error("fast PWM did not set on top");

    chk_phase_clear_up: assert property (
        (cfg.mode == TPCU_MODE_PHASE && cfg.ocmode == TPCU_OC_CLEAR && cmp_evt && count_up
         && !cmd_reset) |=> !timer_out)
        else $error("phase PWM did not clear counting up");

    chk_phase_set_up: assert property (
        (cfg.mode == TPCU_MODE_PHASE && cfg.ocmode == TPCU_OC_SET && cmp_evt && count_up
         && !cmd_reset) |=> timer_out)
        else $error("phase PWM did not set counting up");

    chk_count_read_back: assert property (
        (setup_ph && !pwrite && paddr == TPCU_ADDR_COUNT)
        |=> prdata[15:0] == $past(count_value))
        else $error("count read mismatch");

    chk_capture_snap: assert property (cmd_capture |=> capture_value == $past(count_value))
        else $error("capture missed the count");

    chk_compare_write: assert property (
        (wr_en && paddr == TPCU_ADDR_CMP) |=> compare_value == $past(pwdata[15:0]))
        else $error("compare value not stored");

endmodule // tpcu_timer

/* testbench/test_timer_pwm_config_unit.sv */
`timescale 1ns/1ps
module test_timer_pwm_config_unit;
    import tpcu_pkg::*;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, timer_out, timer_irq, err;
    logic        osc_clk = 1'b0;
    logic [1:0]  osc_div = 2'h0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, a;
    int          n_mismatch = 0, total_checks = 0, cycles = 0, n, i;
    logic [2:0]  cs_t[8] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [2:0]  dv_t[8] = '{TPCU_DIV_1, TPCU_DIV_1, TPCU_DIV_1, TPCU_DIV_1, TPCU_DIV_8,
                             TPCU_DIV_64, TPCU_DIV_256, TPCU_DIV_1024};
    int          ex_t[8] = '{2, 2, 12, 12, 16, 128, 512, 2048};

    tpcu_timer u_tpcu_timer (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_clk(osc_clk), .timer_out(timer_out), .timer_irq(timer_irq));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Oscillator stand-in and run limit
    // ************************************************************
    // The oscillator runs free with a period of six bus cycles.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
        if (osc_div == 2'h2) osc_clk <= ~osc_clk;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic setup(input logic [1:0] md, oc, input logic [2:0] cs, dv, input logic ie,
                         input logic [15:0] top, cmp);
        apb(1'b1, TPCU_ADDR_CMD, 32'h1);
        apb(1'b1, TPCU_ADDR_CTRL, {21'h0, ie, dv, cs, oc, md});
        apb(1'b1, TPCU_ADDR_TOP, {16'h0, top});
        apb(1'b1, TPCU_ADDR_CMP, {16'h0, cmp});
        apb(1'b1, TPCU_ADDR_CMD, 32'h6);
    endtask

    // Skips any partial run so only a whole stretch at level v is counted.
    task automatic run_len(input logic v, output int len);
        len = 0;
        @(posedge sys_clk);
        while (timer_out !== ~v) @(posedge sys_clk);
        while (timer_out !== v) @(posedge sys_clk);
        while (timer_out === v) begin
            len++;
            @(posedge sys_clk);
        end
    endtask

    task automatic test_regs;
        apb(1'b0, TPCU_ADDR_TOP, 32'h0); chk(rd, 32'h0000_ffff);
        chk({30'h0, pready, err}, 32'h2);
        apb(1'b0, TPCU_ADDR_CMP, 32'h0); chk(rd, 32'h0);
        apb(1'b1, TPCU_ADDR_CMP, 32'h0000_ffff);
        apb(1'b0, TPCU_ADDR_CMP, 32'h0); chk(rd, 32'h0000_ffff);
        apb(1'b0, 8'h1c, 32'h0); chk({31'h0, err}, 32'h1);
        apb(1'b1, TPCU_ADDR_COUNT, 32'h5); chk({31'h0, err}, 32'h1);
        $display("test regs done");
    endtask

    task automatic test_clear;
        setup(TPCU_MODE_CLEAR, TPCU_OC_TOGGLE, 3'h0, TPCU_DIV_1, 1'b1, 16'h4, 16'h0);
        run_len(1'b1, n); chk(n, 5);
        chk({31'h0, timer_irq}, 32'h1);
        apb(1'b0, TPCU_ADDR_STAT, 32'h0); chk(rd & 32'h1, 32'h1);
        apb(1'b1, TPCU_ADDR_CTRL,
            {21'h0, 1'b0, TPCU_DIV_1, 3'h0, TPCU_OC_TOGGLE, TPCU_MODE_CLEAR});
        repeat (2) @(posedge sys_clk);
        chk({31'h0, timer_irq}, 32'h0);
        for (i = 0; i < 2; i++) begin
            setup(i[1:0], TPCU_OC_SET, 3'h0, TPCU_DIV_1, 1'b0, 16'h3, 16'h0);
            repeat (8) @(posedge sys_clk);
            chk({31'h0, timer_out}, 32'h1);
        end
        setup(TPCU_MODE_FAST, TPCU_OC_ZERO, 3'h0, TPCU_DIV_1, 1'b0, 16'h3, 16'h1);
        n = 0;
        repeat (30) @(posedge sys_clk) n += timer_out;
        chk(n, 0);
        $display("test clear done");
    endtask

    task automatic test_pwm;
        setup(TPCU_MODE_FAST, TPCU_OC_TOGGLE, 3'h0, TPCU_DIV_1, 1'b0, 16'h9, 16'h3);
        run_len(1'b1, n); chk(n, 10);
        for (i = 2; i < 4; i++) begin
            setup(TPCU_MODE_FAST, i[1:0], 3'h0, TPCU_DIV_1, 1'b0, 16'h9, 16'h3);
            run_len(1'b1, n); chk(n, (i == 2) ? 6 : 4);
            setup(TPCU_MODE_PHASE, i[1:0], 3'h0, TPCU_DIV_1, 1'b0, 16'h8, 16'h3);
            run_len(i == 3, n); chk(n, 10);
        end
        $display("test pwm done");
    endtask

    task automatic test_clk;
        for (i = 0; i < 8; i++) begin
            setup(TPCU_MODE_CLEAR, TPCU_OC_TOGGLE, cs_t[i], dv_t[i], 1'b0, 16'h1, 16'h0);
            run_len(1'b1, n); chk(n, ex_t[i]);
        end
        setup(TPCU_MODE_CLEAR, TPCU_OC_TOGGLE, 3'h0, TPCU_DIV_STOP, 1'b0, 16'hffff, 16'h0);
        repeat (10) @(posedge sys_clk);
        apb(1'b0, TPCU_ADDR_COUNT, 32'h0); chk(rd, 32'h0);
        $display("test clk done");
    endtask

    task automatic test_cmd;
        setup(TPCU_MODE_CLEAR, TPCU_OC_TOGGLE, 3'h0, TPCU_DIV_1, 1'b0, 16'hffff, 16'h0);
        repeat (20) @(posedge sys_clk);
        apb(1'b1, TPCU_ADDR_CMD, 32'h1);
        apb(1'b0, TPCU_ADDR_COUNT, 32'h0); a = rd;
        apb(1'b0, TPCU_ADDR_COUNT, 32'h0); chk(rd, a);
        apb(1'b1, TPCU_ADDR_CMD, 32'h8);
        apb(1'b0, TPCU_ADDR_CAP, 32'h0); chk(rd, a);
        apb(1'b1, TPCU_ADDR_CMD, 32'h2);
        apb(1'b0, TPCU_ADDR_COUNT, 32'h0); chk(rd, 32'h0);
        apb(1'b1, TPCU_ADDR_CMD, 32'h4);
        apb(1'b0, TPCU_ADDR_COUNT, 32'h0); a = rd;
        apb(1'b0, TPCU_ADDR_COUNT, 32'h0); chk(rd - a, 32'h3);
        $display("test cmd done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        test_regs();
        test_clear();
        test_pwm();
        test_clk();
        test_cmd();
        complete_run();
    end
endmodule // test_timer_pwm_config_unit
